// ---- logic/aelc_top.sv ----
// active energy line-cycle accumulation with fundamental var scaling
`timescale 1ns/1ps
`include "aelc_map.svh"
module aelc_top (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire aelc_pkg::aelc_bus_s bus,
    output aelc_pkg::aelc_word_t rdata,
    input wire aelc_pkg::aelc_phase_s ph [3],
    input wire logic [2:0] zero_cross,
    input wire logic waveform_mode,
    output logic signed [24:0] phase_b_rms_src,
    output aelc_pkg::aelc_word_t capture_fvar [3],
    output logic capture_valid,
    output logic interrupt_line_zero_b
);
    import aelc_pkg::*;

    // sample tick: fractional divider, no drift over time
    logic [31:0] tick_acc;
    logic tick;
    wire [32:0] tick_sum = {1'b0, tick_acc} + 33'(`AELC_ACC_HZ);
    wire tick_wrap = tick_sum >= 33'(`AELC_CLK_HZ);
    wire [32:0] tick_next = tick_wrap ? tick_sum - 33'(`AELC_CLK_HZ) : tick_sum;
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            tick_acc <= 32'h0;
            tick <= 1'b0;
        end else begin
            tick_acc <= tick_next[31:0];
            tick <= tick_wrap;
        end
    end

    // software registers
    logic [7:0] energy_threshold;
    logic [7:0] accumulation_mode_reg;
    logic [7:0] line_cycle_mode_reg;
    logic [15:0] half_cycle_count;
    logic [7:0] int_mask_zero;
    logic line_energy_done_flag;
    wire [1:0] connection_select =
        accumulation_mode_reg[`AELC_ACC_CONNECTION_SELECT_LO +: 2];
    wire aelc_accumulation_mode_reg_e power_accumulate_mode =
        aelc_accumulation_mode_reg_e'(accumulation_mode_reg[`AELC_ACC_POWER_ACCUMULATE_MODE_LO +: 2]);
    wire line_energy_enable = line_cycle_mode_reg[`AELC_LCM_LINE_ENERGY_ENABLE];
    wire clear_on_read_enable = line_cycle_mode_reg[`AELC_LCM_CLEAR_ON_READ_ENABLE];
    wire [2:0] zero_cross_phase_select =
        line_cycle_mode_reg[`AELC_LCM_ZERO_CROSS_PHASE_SELECT_LO +: 3];

    // address decode
    wire wr_thr = bus.wr && bus.addr == `AELC_OFF_THRESH;
    wire wr_acc = bus.wr && bus.addr == `AELC_OFF_ACCUMULATION_MODE_REG;
    wire wr_lcm = bus.wr && bus.addr == `AELC_OFF_LINE_CYCLE_MODE_REG;
    wire wr_hcc = bus.wr && bus.addr == `AELC_OFF_HCC;
    wire wr_st = bus.wr && bus.addr == `AELC_OFF_STATUS_REG_ZERO;
    wire wr_msk = bus.wr && bus.addr == `AELC_OFF_INT_MASK_ZERO;
    wire [7:0] e_rel = bus.addr - `AELC_OFF_ENERGY;
    wire rd_energy = bus.rd && bus.addr >= `AELC_OFF_ENERGY &&
        e_rel < 8'h18 && e_rel[1:0] == 2'b00;
    wire [2:0] e_idx = e_rel[4:2];

    // phase b voltage formula per connection select
    wire signed [24:0] va = 25'(ph[0].v);
    wire signed [24:0] vc = 25'(ph[2].v);
    wire signed [24:0] fva = 25'(ph[0].fv);
    wire signed [24:0] fvc = 25'(ph[2].fv);
    logic signed [24:0] vb_sel;
    logic signed [24:0] fvb_sel;
    always_comb begin
        unique case (connection_select)
            2'b00: begin
                vb_sel = 25'(ph[1].v);
                fvb_sel = 25'(ph[1].fv);
            end
            2'b01: begin
                vb_sel = va - vc;
                fvb_sel = fva - fvc;
            end
            2'b10: begin
                vb_sel = -va - vc;
                fvb_sel = -fva - fvc;
            end
            2'b11: begin
                vb_sel = -va;
                fvb_sel = -fva;
            end
        endcase
    end

    // power word: full-scale sine averages to full_scale_power_constant
    function automatic logic signed [31:0] pwr(
        input logic signed [24:0] v, input logic signed [23:0] i);
        logic signed [75:0] p;
        p = 76'(v * i) * $signed({1'b0, `AELC_FULL_SCALE_POWER_CONSTANT});
        return 32'(p >>> `AELC_PWR_SHIFT);
    endfunction

    // accumulate mode shaping of a power sample
    function automatic logic signed [31:0] shape(
        input logic signed [31:0] p, input aelc_accumulation_mode_reg_e m);
        unique case (m)
            AELC_ACC_POS: return p[31] ? 32'sh0 : p;
            AELC_ACC_ABS: return p[31] ? -p : p;
            default: return p;
        endcase
    endfunction

    // index 0..2 total, 3..5 fundamental, same formula for both
    logic signed [31:0] pw [6];
    always_comb begin
        pw[0] = pwr(va, ph[0].i);
        pw[1] = pwr(vb_sel, ph[1].i);
        pw[2] = pwr(vc, ph[2].i);
        pw[3] = pwr(fva, ph[0].fi);
        pw[4] = pwr(fvb_sel, ph[1].fi);
        pw[5] = pwr(fvc, ph[2].fi);
    end

    // zero crossing count: always running
    logic [15:0] zx_cnt;
    wire [2:0] zx_hit = zero_cross & zero_cross_phase_select;
    wire [1:0] zx_n = 2'(zx_hit[0]) + 2'(zx_hit[1]) + 2'(zx_hit[2]);
    wire zx_end = zx_n != 2'd0 && zx_cnt <= 16'(zx_n);
    wire line_xfer = zx_end && line_energy_enable;
    // reload on write while line mode is on
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            zx_cnt <= `AELC_RST_HCC;
        end else if (wr_hcc && line_energy_enable) begin
            zx_cnt <= bus.wdata[15:0];
        end else if (zx_end) begin
            zx_cnt <= half_cycle_count;
        end else begin
            zx_cnt <= zx_cnt - 16'(zx_n);
        end
    end

    wire signed [39:0] thresh =
        40'({energy_threshold, {`AELC_THRESH_PAD{1'b0}}});
    logic signed [39:0] stage1 [6];
    aelc_word_t e_int [6];
    aelc_word_t e_line [6];
    genvar g;
    generate
        for (g = 0; g < 6; g++) begin : g_acc
            wire signed [39:0] s1_sum =
                stage1[g] + 40'(shape(pw[g], power_accumulate_mode));
            wire pos_hit = tick && s1_sum >= thresh;
            wire neg_hit = tick && s1_sum <= -thresh;
            wire signed [31:0] step =
                pos_hit ? 32'sh1 : (neg_hit ? -32'sh1 : 32'sh0);
            wire rd_clr = rd_energy && e_idx == 3'(g) &&
                clear_on_read_enable && !line_energy_enable;
            always_ff @(posedge core_clk or negedge rst_b) begin
                if (!rst_b) begin
                    stage1[g] <= 40'sh0;
                end else if (tick) begin
                    stage1[g] <= pos_hit ? s1_sum - thresh :
                        (neg_hit ? s1_sum + thresh : s1_sum);
                end
            end
            // restart sum; the step of the transfer cycle counts in both periods
            always_ff @(posedge core_clk or negedge rst_b) begin
                if (!rst_b) begin
                    e_int[g] <= 32'sh0;
                    e_line[g] <= 32'sh0;
                end else begin
                    e_int[g] <= (line_xfer || rd_clr) ? step : e_int[g] + step;
                    if (line_xfer) begin
                        e_line[g] <= e_int[g] + step;
                    end
                end
            end
        end
    endgenerate

    // register writes; 16-bit count register
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            energy_threshold <= `AELC_RST_THRESH;
            accumulation_mode_reg <= `AELC_RST_ACCUMULATION_MODE_REG;
            line_cycle_mode_reg <= `AELC_RST_LINE_CYCLE_MODE_REG;
            half_cycle_count <= `AELC_RST_HCC;
            int_mask_zero <= 8'h00;
        end else begin
            if (wr_thr) energy_threshold <= bus.wdata[7:0];
            if (wr_acc) accumulation_mode_reg <= {2'b00, bus.wdata[5:4],
                2'b00, bus.wdata[1:0]};
            if (wr_lcm) line_cycle_mode_reg <= {1'b0, bus.wdata[6:0]};
            if (wr_hcc) half_cycle_count <= bus.wdata[15:0];
            if (wr_msk) int_mask_zero <= bus.wdata[7:0];
        end
    end

    // set on period end; write-one clear, set wins
    wire st_clr = wr_st && bus.wdata[`AELC_ST_LINE_ENERGY_DONE_FLAG];
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            line_energy_done_flag <= 1'b0;
            interrupt_line_zero_b <= 1'b1;
        end else begin
            line_energy_done_flag <= line_xfer ||
                (line_energy_done_flag && !st_clr);
            interrupt_line_zero_b <= !((line_xfer ||
                (line_energy_done_flag && !st_clr)) &&
                int_mask_zero[`AELC_ST_LINE_ENERGY_DONE_FLAG]);
        end
    end

    // read mux: normal mode reads live sums, line mode the latched copy
    wire [7:0] st_word = 8'(line_energy_done_flag) << `AELC_ST_LINE_ENERGY_DONE_FLAG;
    aelc_word_t rd_mux;
    always_comb begin
        rd_mux = 32'sh0;
        if (rd_energy) begin
            rd_mux = line_energy_enable ? e_line[e_idx] : e_int[e_idx];
        end else if (bus.rd) begin
            unique case (bus.addr)
                `AELC_OFF_THRESH: rd_mux = 32'(energy_threshold);
                `AELC_OFF_ACCUMULATION_MODE_REG: rd_mux = 32'(accumulation_mode_reg);
                `AELC_OFF_LINE_CYCLE_MODE_REG: rd_mux = 32'(line_cycle_mode_reg);
                `AELC_OFF_HCC: rd_mux = 32'(half_cycle_count);
                `AELC_OFF_STATUS_REG_ZERO: rd_mux = 32'(st_word);
                `AELC_OFF_INT_MASK_ZERO: rd_mux = 32'(int_mask_zero);
                default: rd_mux = 32'sh0;
            endcase
        end
    end

    // read data stands exactly one cycle after the strobe
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata <= 32'sh0;
        end else begin
            rdata <= rd_mux;
        end
    end

    // three-wire: line voltage a-c feeds the phase b rms engine
    // var scaled by full_scale_power_constant over 16
    // var words only on the capture port in waveform mode
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            phase_b_rms_src <= 25'sh0;
            capture_valid <= 1'b0;
            for (int k = 0; k < 3; k++) capture_fvar[k] <= 32'sh0;
        end else begin
            phase_b_rms_src <= connection_select == 2'b01 ? va - vc :
                25'(ph[1].v);
            capture_valid <= waveform_mode && tick;
            for (int k = 0; k < 3; k++) begin
                capture_fvar[k] <= waveform_mode ? 32'((76'(ph[k].fq) *
                    $signed({1'b0, `AELC_FULL_SCALE_POWER_CONSTANT})) >>>
                    (`AELC_PWR_SHIFT + `AELC_FVAR_SHIFT)) : 32'sh0;
            end
        end
    end

    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    property p_flag_set;
        line_xfer |=> line_energy_done_flag;
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("flag not set");
    property p_irq;
        line_xfer && int_mask_zero[5] |=> !interrupt_line_zero_b;
    endproperty
    a_irq: assert property (p_irq) else $error("irq not low");
    property p_clear;
        line_energy_done_flag && st_clr && !line_xfer
            |=> !line_energy_done_flag ##0 interrupt_line_zero_b;
    endproperty
    a_clear: assert property (p_clear) else $error("flag not cleared");
    property p_reload;
        wr_hcc && line_energy_enable |=> zx_cnt == $past(bus.wdata[15:0]);
    endproperty
    a_reload: assert property (p_reload) else $error("no reload");
    property p_step;
        !wr_hcc && !zx_end |=> zx_cnt == $past(zx_cnt) - 16'($past(zx_n));
    endproperty
    a_step: assert property (p_step) else $error("bad count step");
    property p_xfer;
        line_xfer |=> e_line[0] == $past(e_int[0]) + $past(g_acc[0].step);
    endproperty
    a_xfer: assert property (p_xfer) else $error("no transfer");
    property p_restart;
        line_xfer && !wr_hcc |=> zx_cnt == $past(half_cycle_count);
    endproperty
    a_restart: assert property (p_restart) else $error("no restart");
    property p_tick;
        tick |=> !tick [*8] ##[1:30] tick;
    endproperty
    a_tick: assert property (p_tick) else $error("tick spacing");
    property p_rms;
        connection_select == 2'b01 |=> phase_b_rms_src == $past(va - vc);
    endproperty
    a_rms: assert property (p_rms) else $error("rms source");
    c_xfer: cover property (line_xfer);
    c_set_clear: cover property (line_xfer && st_clr);
    c_pulse: cover property (g_acc[1].neg_hit);
    c_capture: cover property (capture_valid);
endmodule

// ---- logic/aelc_map.svh ----
// register offsets, field positions, reset values and timing counts
`ifndef AELC_MAP_SVH
`define AELC_MAP_SVH
`define AELC_OFF_THRESH 8'h00
`define AELC_OFF_ACCUMULATION_MODE_REG 8'h04
`define AELC_OFF_LINE_CYCLE_MODE_REG 8'h08
`define AELC_OFF_HCC 8'h0c
`define AELC_OFF_STATUS_REG_ZERO 8'h10
`define AELC_OFF_INT_MASK_ZERO 8'h14
`define AELC_OFF_ENERGY 8'h18
`define AELC_ACC_POWER_ACCUMULATE_MODE_LO 0
`define AELC_ACC_CONNECTION_SELECT_LO 4
`define AELC_LCM_LINE_ENERGY_ENABLE 0
`define AELC_LCM_ZERO_CROSS_PHASE_SELECT_LO 3
`define AELC_LCM_CLEAR_ON_READ_ENABLE 6
`define AELC_ST_LINE_ENERGY_DONE_FLAG 5
`define AELC_RST_THRESH 8'h03
`define AELC_RST_ACCUMULATION_MODE_REG 8'h00
`define AELC_RST_LINE_CYCLE_MODE_REG 8'h38
`define AELC_RST_HCC 16'hffff
`define AELC_THRESH_PAD 27
`define AELC_FULL_SCALE_POWER_CONSTANT 26'h19ce5de
`define AELC_PWR_SHIFT 45
`define AELC_FVAR_SHIFT 4
`define AELC_CLK_HZ 25000000
`define AELC_SAMPLE_PS_X16 15625000
`define AELC_ACC_HZ (64'd16000000000000 / `AELC_SAMPLE_PS_X16)
`endif

// ---- logic/aelc_pkg.sv ----
// types shared by the energy accumulation block
package aelc_pkg;
    // one phase of dsp samples, all signed
    typedef struct packed {
        logic signed [23:0] v;
        logic signed [23:0] i;
        logic signed [23:0] fv;
        logic signed [23:0] fi;
        logic signed [47:0] fq;
    } aelc_phase_s;
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } aelc_bus_s;
    typedef enum logic [1:0] {
        AELC_ACC_SIGNED,
        AELC_ACC_POS,
        AELC_ACC_RSVD,
        AELC_ACC_ABS
    } aelc_accumulation_mode_reg_e;
    typedef logic signed [31:0] aelc_word_t;
endpackage

// ---- verification/aelc_top_tb.sv ----
// self-checking bench for the energy line-cycle accumulation block
`timescale 1ns/1ps
`include "aelc_map.svh"
module aelc_top_tb;
    import aelc_pkg::*;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    aelc_bus_s bus = '0;
    aelc_word_t rdata;
    aelc_phase_s ph [3];
    logic [2:0] zero_cross = 3'h0;
    logic waveform_mode = 1'b0;
    logic signed [24:0] phase_b_rms_src;
    aelc_word_t capture_fvar [3];
    logic capture_valid;
    logic interrupt_line_zero_b;
    int errors = 0;
    int comparisons = 0;
    int cycles = 0;
    int n;
    logic [31:0] got;
    // reset read rows: address beside expected word, last one unmapped
    logic [7:0] rd_addr [6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h14, 8'h40};
    logic [31:0] rd_exp [6] = '{32'h3, 32'h0, 32'h38, 32'hffff, 32'h0, 32'h0};
    // connection select rows: phase b source for codes 00..11
    logic [31:0] cs_exp [4] = '{32'h7, 32'h46, 32'h7, 32'h7};
    // energy rows: mode word, then each energy word as a multiple of a
    logic [31:0] acc_row [2] = '{32'h30, 32'h31};
    int e_mul [2][6] = '{'{1, -1, 0, 1, -1, 0}, '{1, 0, 0, 1, 0, 0}};
    int ea;

    aelc_top i_aelc_top (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .bus(bus),
        .rdata(rdata),
        .ph(ph),
        .zero_cross(zero_cross),
        .waveform_mode(waveform_mode),
        .phase_b_rms_src(phase_b_rms_src),
        .capture_fvar(capture_fvar),
        .capture_valid(capture_valid),
        .interrupt_line_zero_b(interrupt_line_zero_b)
    );

    // 25 mhz core clock
    always #20 core_clk = ~core_clk;

    // hang guard at 5000 cycles, about twice the 2300 or so cycles the run needs
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            errors = errors + 1;
            results();
        end
    end

    task automatic results();
        $display("checks %0d mismatches %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic check32(input string name, input logic [31:0] exp,
                           input logic [31:0] seen);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic check1(input string name, input logic exp,
                          input logic seen);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %s expected %b seen %b", name, exp, seen);
        end
    endtask

    // one-cycle write strobe, taken on the following edge
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        bus.addr <= a;
        bus.wdata <= d;
        bus.wr <= 1'b1;
        @(posedge core_clk);
        bus.wr <= 1'b0;
    endtask

    // read data stands only in the cycle after the strobe
    task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge core_clk);
        bus.addr <= a;
        bus.rd <= 1'b1;
        @(posedge core_clk);
        bus.rd <= 1'b0;
        #1 d = rdata;
    endtask

    // n back-to-back crossing pulses, held as one level, then released
    task automatic zc_pulse(input logic [2:0] v, input int cnt);
        for (int k = 0; k < cnt; k++) begin
            @(posedge core_clk);
            zero_cross <= v;
        end
        @(posedge core_clk);
        zero_cross <= 3'h0;
    endtask

    // settle two cycles, then interrupt level and done flag
    task automatic flag_is(input logic f, input logic irq_b);
        repeat (2) @(posedge core_clk);
        #1 check1("interrupt line", irq_b, interrupt_line_zero_b);
        reg_rd(`AELC_OFF_STATUS_REG_ZERO, got);
        check1("done flag", f, got[`AELC_ST_LINE_ENERGY_DONE_FLAG]);
    endtask

    initial begin
        for (int k = 0; k < 3; k++) ph[k] = '0;
        repeat (6) @(posedge core_clk);
        rst_b <= 1'b1;
        for (int k = 0; k < 6; k++) begin
            reg_rd(rd_addr[k], got);
            check32("reset read", rd_exp[k], got);
        end
        @(posedge core_clk);
        ph[0].v <= 24'sd100;
        ph[1].v <= 24'sd7;
        ph[2].v <= 24'sd30;
        for (int k = 0; k < 4; k++) begin
            reg_wr(`AELC_OFF_ACCUMULATION_MODE_REG, {26'h0, k[1:0], 4'h0});
            repeat (2) @(posedge core_clk);
            #1 check32("b source", cs_exp[k], 32'(phase_b_rms_src));
        end
        // full-scale quadrature product, both signs, scaled by full_scale_power_constant/16
        @(posedge core_clk);
        ph[0].fq <= 48'sh2000_0000_0000;
        ph[1].fq <= -48'sh2000_0000_0000;
        waveform_mode <= 1'b1;
        for (int p = 0; p < 2; p++) begin
            n = 0;
            @(posedge core_clk);
            #1;
            while (capture_valid !== 1'b1 && n < 100) begin
                @(posedge core_clk);
                #1 n++;
            end
        end
        check1("capture tick", 1'b1, capture_valid);
        check32("fvar a", 32'h0019ce5d, capture_fvar[0]);
        check32("fvar b", 32'hffe631a2, capture_fvar[1]);
        check32("fvar c", 32'h0, capture_fvar[2]);
        @(posedge core_clk);
        waveform_mode <= 1'b0;
        n = 0;
        repeat (60) begin
            @(posedge core_clk);
            #1 n = n + int'(capture_valid === 1'b1);
        end
        check32("ticks off mode", 32'h0, 32'(n));
        check32("fvar off mode", 32'h0, capture_fvar[0]);
        // line mode on phase a, masked in, period of two crossings
        // clear-on-read off, one phase
        reg_wr(`AELC_OFF_LINE_CYCLE_MODE_REG, 32'h9);
        reg_wr(`AELC_OFF_INT_MASK_ZERO, 32'h20);
        reg_wr(`AELC_OFF_HCC, 32'h2);
        zc_pulse(3'b110, 3);
        flag_is(1'b0, 1'b1);
        zc_pulse(3'b001, 2);
        flag_is(1'b1, 1'b0);
        reg_wr(`AELC_OFF_STATUS_REG_ZERO, 32'h20);
        flag_is(1'b0, 1'b1);
        // next period runs on without any rewrite of the count
        zc_pulse(3'b001, 1);
        flag_is(1'b0, 1'b1);
        zc_pulse(3'b001, 1);
        flag_is(1'b1, 1'b0);
        reg_wr(`AELC_OFF_STATUS_REG_ZERO, 32'h20);
        // a count write in line mode restarts the crossing counter
        reg_wr(`AELC_OFF_HCC, 32'h3);
        zc_pulse(3'b001, 2);
        reg_wr(`AELC_OFF_HCC, 32'h3);
        zc_pulse(3'b001, 2);
        flag_is(1'b0, 1'b1);
        zc_pulse(3'b001, 1);
        flag_is(1'b1, 1'b0);
        reg_wr(`AELC_OFF_STATUS_REG_ZERO, 32'h20);
        // phases a and c together, mask off: flag only, line stays high
        reg_wr(`AELC_OFF_LINE_CYCLE_MODE_REG, 32'h29);
        reg_wr(`AELC_OFF_INT_MASK_ZERO, 32'h0);
        reg_wr(`AELC_OFF_HCC, 32'h2);
        zc_pulse(3'b101, 1);
        flag_is(1'b1, 1'b1);
        reg_wr(`AELC_OFF_STATUS_REG_ZERO, 32'h20);
        flag_is(1'b0, 1'b1);
        // energy words: code 11 feeds a inverted into b, c carries no current
        // clear-on-read off, one phase
        reg_wr(`AELC_OFF_LINE_CYCLE_MODE_REG, 32'h9);
        reg_wr(`AELC_OFF_THRESH, 32'h1);
        reg_wr(`AELC_OFF_HCC, 32'h2);
        @(posedge core_clk);
        ph[0].v <= 24'sh400000;
        ph[0].i <= 24'sh400000;
        ph[0].fv <= 24'sh400000;
        ph[0].fi <= 24'sh400000;
        ph[1].i <= 24'sh400000;
        ph[1].fi <= 24'sh400000;
        for (int p = 0; p < 2; p++) begin
            reg_wr(`AELC_OFF_ACCUMULATION_MODE_REG, acc_row[p]);
            // first pair restarts the sums under the new mode
            zc_pulse(3'b001, 2);
            repeat (1000) @(posedge core_clk);
            zc_pulse(3'b001, 2);
            reg_rd(`AELC_OFF_ENERGY, got);
            ea = int'(got);
            check1("energy a pulses", 1'b1, ea >= 3);
            for (int k = 0; k < 6; k++) begin
                reg_rd(8'(`AELC_OFF_ENERGY + 4 * k), got);
                check32("energy word", 32'(e_mul[p][k] * ea), got);
            end
        end
        results();
    end
endmodule
